// ### rtl/dcrf_core.sv
// cpu register file: accumulators, temporaries, pointers and upper mapped words
`timescale 1ns/10ps
`default_nettype none
module dcrf_core (
    input  wire logic                clk_sys,      // system clock
    input  wire logic                sys_rst,      // synchronous reset, high
    input  wire logic                clk_en,       // freezes all state when low
    input  wire dcrf_pkg::dcrf_mmr_s mmr_i,        // mapped register access
    input  wire dcrf_pkg::dcrf_cmd_s cmd_i,        // instruction command
    input  wire dcrf_pkg::dcrf_dag_s dag_i,        // address generator step
    input  wire logic                legacy_compat_mode, // legacy mode bit
    input  wire logic [4:0]          accumulator_shift_mode_field, // shift field
    output logic [15:0]              mmr_rdata,    // read data, one cycle after rd
    output logic [159:0]             acc_o,        // accumulators 3..0
    output logic [63:0]              tmp_o,        // temporaries 3..0
    output logic [183:0]             ptr_o,        // extended pointers 7..0
    output logic [31:0]              trn_o,        // transition 1, 0
    output logic [15:0]              status_two,   // status register two
    output logic [10:0]              interrupt_enable_1, // enable one
    output logic [10:0]              interrupt_flag_1,   // flag one
    output logic                     bad_instr     // invalid command pulse
);
    import dcrf_pkg::*;

    typedef struct packed {
        logic [3:0][39:0] acc;
        logic [3:0][15:0] tmp;
        logic [7:0][22:0] ptr;
        logic [1:0][15:0] trn;
        logic [10:0]      ien1;
        logic [10:0]      ifl1;
        logic [15:0]      dien0;
        logic [10:0]      dien1;
        logic [15:0]      vp_main;
        logic [15:0]      vp_host;
        logic [15:0]      st2;
        logic [15:0]      sys_stk;
        logic [15:0]      dsp;
        logic [6:0]       stk_pg;
        logic [6:0]       cph;
        logic [15:0]      rdata;
        logic             bad;
    } dcrf_state_s;

    dcrf_state_s s_q;
    dcrf_state_s s_d;

    // accumulator portions, pointer low parts and temporaries each fill a run of words
    function automatic logic in_span(input logic [6:0] a, input logic [6:0] base, input logic [6:0] n);
        return (a >= base) && (a < base + n);
    endfunction

    // which accumulator and portion a word address selects; portion 3 = none
    function automatic logic [3:0] acc_decode(input logic [6:0] a);
        logic [3:0] r;
        r = 4'h3;
        if (in_span(a, A_ACC0, 7'd3)) begin
            r = {2'd0, 2'(a - A_ACC0)};
        end else if (in_span(a, A_ACC1, 7'd3)) begin
            r = {2'd1, 2'(a - A_ACC1)};
        end else if (in_span(a, A_ACC2, 7'd3)) begin
            r = {2'd2, 2'(a - A_ACC2)};
        end else if (in_span(a, A_ACC3, 7'd3)) begin
            r = {2'd3, 2'(a - A_ACC3)};
        end
        return r;
    endfunction

    function automatic logic [15:0] acc_part(input logic [39:0] v, input logic [1:0] p);
        logic [15:0] r;
        case (p)
            2'd0:    r = v[15:0];
            2'd1:    r = v[31:16];
            2'd2:    r = {8'h00, v[39:32]};
            default: r = RST_WORD;
        endcase
        return r;
    endfunction

    // signed extremum decision: 1 when b beats a
    function automatic logic pick_b(input logic [39:0] a, input logic [39:0] b,
                                    input logic want_max);
        logic gt;
        gt = $signed(b) > $signed(a);
        return want_max ? gt : ($signed(b) < $signed(a));
    endfunction

    logic [3:0]  dec;
    logic [15:0] rd_v;

    always_comb begin
        dec  = acc_decode(mmr_i.addr);
        rd_v = RST_WORD;
        if (dec[1:0] != 2'd3) begin
            rd_v = acc_part(s_q.acc[dec[3:2]], dec[1:0]);
        end else if (in_span(mmr_i.addr, A_PTR, 7'd8)) begin
            rd_v = s_q.ptr[3'(mmr_i.addr - A_PTR)][15:0];
        end else if (in_span(mmr_i.addr, A_TMP, 7'd4)) begin
            rd_v = s_q.tmp[2'(mmr_i.addr - A_TMP)];
        end else begin
            case (mmr_i.addr)
                A_TRANS0: rd_v = s_q.trn[0];
                A_TRANS1: rd_v = s_q.trn[1];
                A_IEN1:   rd_v = {5'd0, s_q.ien1};
                A_IFL1:   rd_v = {5'd0, s_q.ifl1};
                A_DIEN0:  rd_v = s_q.dien0;
                A_DIEN1:  rd_v = {5'd0, s_q.dien1};
                A_VPMAIN: rd_v = s_q.vp_main;
                A_VPHOST: rd_v = s_q.vp_host;
                A_ST2:    rd_v = s_q.st2;
                A_SYSSTK: rd_v = s_q.sys_stk;
                A_DSP:    rd_v = s_q.dsp;
                A_STKPG:  rd_v = {9'd0, s_q.stk_pg};
                A_CPH:    rd_v = {9'd0, s_q.cph};
                default:  rd_v = RST_WORD;
            endcase
        end
    end

    logic [39:0] va;
    logic [39:0] vb;
    logic [15:0] pl;
    logic [15:0] alu_r;
    logic        hi_b;
    logic        lo_b;
    logic        all_b;
    logic        wmax;

    always_comb begin
        s_d   = s_q;
        s_d.bad = 1'b0;
        va    = s_q.acc[cmd_i.ia[1:0]];
        vb    = s_q.acc[cmd_i.ib[1:0]];
        pl    = s_q.ptr[cmd_i.ib][15:0];
        wmax  = (cmd_i.op == OP_MAX_DUAL) || (cmd_i.op == OP_MAX_40);
        hi_b  = pick_b({{24{va[31]}}, va[31:16]}, {{24{vb[31]}}, vb[31:16]}, wmax);
        lo_b  = pick_b({{24{va[15]}}, va[15:0]}, {{24{vb[15]}}, vb[15:0]}, wmax);
        all_b = pick_b(va, vb, wmax);
        case (cmd_i.fn)
            AF_ADD:  alu_r = pl + cmd_i.data[15:0];
            AF_SUB:  alu_r = pl - cmd_i.data[15:0];
            AF_AND:  alu_r = pl & cmd_i.data[15:0];
            AF_OR:   alu_r = pl | cmd_i.data[15:0];
            AF_XOR:  alu_r = pl ^ cmd_i.data[15:0];
            AF_SHL:  alu_r = pl << cmd_i.data[3:0];
            AF_SHR:  alu_r = 16'($signed(pl) >>> cmd_i.data[3:0]);
            default: alu_r = pl;
        endcase

        // address generator steps run beside the alu; alu wins on the same pointer
        if (dag_i.en) begin
            s_d.ptr[dag_i.idx][15:0] = s_q.ptr[dag_i.idx][15:0] + dag_i.step;
        end

        case (cmd_i.op)
            OP_ACC_WR:  s_d.acc[cmd_i.ia[1:0]] = cmd_i.data;
            OP_ACC_SWAP: begin
                // only 0/2 and 1/3 share a swap path
                if (cmd_i.ia[1:0] == (cmd_i.ib[1:0] ^ 2'd2)) begin
                    s_d.acc[cmd_i.ia[1:0]] = vb;
                    s_d.acc[cmd_i.ib[1:0]] = va;
                end else begin
                    s_d.bad = 1'b1;
                end
            end
            OP_MAX_DUAL, OP_MIN_DUAL: begin
                s_d.trn[0] = {s_q.trn[0][14:0], hi_b};
                s_d.trn[1] = {s_q.trn[1][14:0], lo_b};
                s_d.acc[cmd_i.ia[1:0]][31:16] = hi_b ? vb[31:16] : va[31:16];
                s_d.acc[cmd_i.ia[1:0]][15:0]  = lo_b ? vb[15:0] : va[15:0];
                s_d.acc[cmd_i.ia[1:0]][39:32] = {8{s_d.acc[cmd_i.ia[1:0]][31]}};
            end
            OP_MAX_40, OP_MIN_40: begin
                s_d.trn[cmd_i.trn_sel] = {s_q.trn[cmd_i.trn_sel][14:0], all_b};
                s_d.acc[cmd_i.ia[1:0]] = all_b ? vb : va;
            end
            OP_T_WR:    s_d.tmp[cmd_i.ia[1:0]] = cmd_i.data[15:0];
            OP_XP_WR:   s_d.ptr[cmd_i.ib] = cmd_i.data[22:0];
            OP_PL_WR:   s_d.ptr[cmd_i.ib][15:0] = cmd_i.data[15:0];
            OP_SWAP_PT: begin
                s_d.tmp[cmd_i.ia[1:0]]   = pl;
                s_d.ptr[cmd_i.ib][15:0] = s_q.tmp[cmd_i.ia[1:0]];
            end
            OP_AU_ALU:  s_d.ptr[cmd_i.ib][15:0] = alu_r;
            default:    s_d.bad = 1'b0;
        endcase

        if (mmr_i.wr) begin
            if (dec[1:0] == 2'd0) begin
                s_d.acc[dec[3:2]][15:0] = mmr_i.wdata;
            end else if (dec[1:0] == 2'd1) begin
                s_d.acc[dec[3:2]][31:16] = mmr_i.wdata;
            end else if (dec[1:0] == 2'd2) begin
                s_d.acc[dec[3:2]][39:32] = mmr_i.wdata[7:0];
            end else if (in_span(mmr_i.addr, A_PTR, 7'd8)) begin
                // page part untouched: only the full pointer reaches it
                s_d.ptr[3'(mmr_i.addr - A_PTR)][15:0] = mmr_i.wdata;
            end else if (in_span(mmr_i.addr, A_TMP, 7'd4)) begin
                s_d.tmp[2'(mmr_i.addr - A_TMP)] = mmr_i.wdata;
            end else begin
                case (mmr_i.addr)
                    A_TRANS0: s_d.trn[0] = mmr_i.wdata;
                    A_TRANS1: s_d.trn[1] = mmr_i.wdata;
                    A_IEN1:   s_d.ien1 = mmr_i.wdata[10:0];
                    A_IFL1:   s_d.ifl1 = mmr_i.wdata[10:0];
                    A_DIEN0:  s_d.dien0 = mmr_i.wdata;
                    A_DIEN1:  s_d.dien1 = mmr_i.wdata[10:0];
                    A_VPMAIN: s_d.vp_main = mmr_i.wdata;
                    A_VPHOST: s_d.vp_host = mmr_i.wdata;
                    A_ST2:    s_d.st2 = mmr_i.wdata;
                    A_SYSSTK: s_d.sys_stk = mmr_i.wdata;
                    A_DSP:    s_d.dsp = mmr_i.wdata;
                    A_STKPG:  s_d.stk_pg = mmr_i.wdata[6:0];
                    A_CPH:    s_d.cph = mmr_i.wdata[6:0];
                    default:  s_d.bad = s_d.bad;
                endcase
            end
        end

        // legacy mode: temporary two mirrors the shift field, sign extended
        if (legacy_compat_mode) begin
            s_d.tmp[2] = {{11{accumulator_shift_mode_field[4]}}, accumulator_shift_mode_field};
        end

        if (mmr_i.rd) begin
            s_d.rdata = rd_v;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_q <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // legacy A and B are accumulator slots 0 and 1 of acc_o
    assign acc_o              = s_q.acc;
    assign tmp_o              = s_q.tmp;
    assign ptr_o              = s_q.ptr;
    assign trn_o              = s_q.trn;
    assign status_two         = s_q.st2;
    assign interrupt_enable_1 = s_q.ien1;
    assign interrupt_flag_1   = s_q.ifl1;
    assign mmr_rdata          = s_q.rdata;
    assign bad_instr          = s_q.bad;
endmodule
`default_nettype wire

// ### rtl/dcrf_pkg.sv
// constants, types and command codes for the cpu register file
// Operation
// - interrupt enable one sits at word 0x45, bits 10..0
// - interrupt flag one sits at word 0x46, bits 10..0
// - debug enables: 16 bits at 0x47, 11 bits at 0x48
// - two 16-bit vector pointers at 0x49 and 0x4A
// - stack pointers at 0x4C, 0x4D; 7-bit shared page at 0x4E
// - 7-bit coefficient pointer high part at 0x4F
// - four equivalent 40-bit accumulators
// - each accumulator splits into low, high and guard words, each mapped
// - accumulator swap allows only pairs 0/2 and 1/3
// - in legacy mode accumulators 0 and 1 are legacy A and B
// - dual extremum: high words update transition 0, low words transition 1
// - 40-bit extremum updates only the selected transition register
// - four 16-bit temporaries serve as multiplicand sources
// - a temporary serves as shift count or transition metric
// - swap exchanges auxiliary pointer low part and temporary contents
// - in legacy mode temporary two follows the shift mode field
// - eight 23-bit pointers: 7-bit page over 16-bit offset
// - pointer low part also serves as bit address, counter, index
// - full pointers only by instruction; low parts also memory mapped
// - pointer page part has no access path of its own
// - address alu works on pointers alongside the address generator
package dcrf_pkg;
    localparam logic [6:0] A_IEN1   = 7'h45;
    localparam logic [6:0] A_IFL1   = 7'h46;
    localparam logic [6:0] A_DIEN0  = 7'h47;
    localparam logic [6:0] A_DIEN1  = 7'h48;
    localparam logic [6:0] A_VPMAIN = 7'h49;
    localparam logic [6:0] A_VPHOST = 7'h4A;
    localparam logic [6:0] A_ST2    = 7'h4B;
    localparam logic [6:0] A_SYSSTK = 7'h4C;
    localparam logic [6:0] A_DSP    = 7'h4D;
    localparam logic [6:0] A_STKPG  = 7'h4E;
    localparam logic [6:0] A_CPH    = 7'h4F;
    localparam logic [6:0] A_ACC0   = 7'h08;
    localparam logic [6:0] A_ACC1   = 7'h0B;
    localparam logic [6:0] A_TRANS0 = 7'h0F;
    localparam logic [6:0] A_PTR    = 7'h10;
    localparam logic [6:0] A_TMP    = 7'h20;
    localparam logic [6:0] A_ACC2   = 7'h24;
    localparam logic [6:0] A_ACC3   = 7'h28;
    localparam logic [6:0] A_TRANS1 = 7'h38;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] MASK11   = 16'h07FF;
    localparam logic [15:0] MASK7    = 16'h007F;

    typedef enum logic [3:0] {
        OP_NONE, OP_ACC_WR, OP_ACC_SWAP, OP_MAX_DUAL, OP_MIN_DUAL, OP_MAX_40,
        OP_MIN_40, OP_T_WR, OP_XP_WR, OP_PL_WR, OP_SWAP_PT, OP_AU_ALU
    } dcrf_op_e;

    typedef enum logic [2:0] {
        AF_ADD, AF_SUB, AF_AND, AF_OR, AF_XOR, AF_SHL, AF_SHR
    } dcrf_alu_e;

    typedef struct packed {
        dcrf_op_e    op;
        logic [2:0]  ia;
        logic [2:0]  ib;
        logic        trn_sel;
        dcrf_alu_e   fn;
        logic [39:0] data;
    } dcrf_cmd_s;

    typedef struct packed {
        logic        en;
        logic [2:0]  idx;
        logic [15:0] step;
    } dcrf_dag_s;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [6:0]  addr;
        logic [15:0] wdata;
    } dcrf_mmr_s;
endpackage

// ### tb/dcrf_core_chk.sv
// assertions on the cpu register file ports
`timescale 1ns/10ps
`default_nettype none
module dcrf_core_chk (
    input wire logic                clk_sys,     // clock
    input wire logic                sys_rst,     // reset
    input wire logic                clk_en,      // enable
    input wire dcrf_pkg::dcrf_mmr_s mmr_i,       // mapped access
    input wire dcrf_pkg::dcrf_cmd_s cmd_i,       // command
    input wire dcrf_pkg::dcrf_dag_s dag_i,       // pointer step
    input wire logic                legacy_compat_mode, // legacy mode
    input wire logic [4:0]          accumulator_shift_mode_field, // shift field
    input wire logic [15:0]         mmr_rdata,   // read data
    input wire logic [63:0]         tmp_o,       // temporaries
    input wire logic [183:0]        ptr_o,       // pointers
    input wire logic [31:0]         trn_o,       // transitions
    input wire logic [10:0]         interrupt_enable_1, // enable one
    input wire logic [10:0]         interrupt_flag_1,   // flag one
    input wire logic                bad_instr    // refused command
);
    import dcrf_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic sw, ok_pair, dag0, x40;
    assign sw = clk_en && cmd_i.op == OP_ACC_SWAP;
    assign ok_pair = cmd_i.ia[1] != cmd_i.ib[1] && cmd_i.ia[0] == cmd_i.ib[0];
    // a command on pointer zero would override the step, so only idle cycles or alu steps on other pointers count
    assign dag0 = clk_en && dag_i.en && dag_i.idx == 3'd0 && !mmr_i.wr
        && (cmd_i.op == OP_NONE || (cmd_i.op == OP_AU_ALU && cmd_i.ib != 3'd0));
    assign x40 = clk_en && !mmr_i.wr && (cmd_i.op == OP_MAX_40 || cmd_i.op == OP_MIN_40);
    a_enable_write: assert property (clk_en && mmr_i.wr && mmr_i.addr == A_IEN1
        |=> interrupt_enable_1 == $past(mmr_i.wdata[10:0])) else $error("enable one write lost");
    a_flag_write: assert property (clk_en && mmr_i.wr && mmr_i.addr == A_IFL1
        |=> interrupt_flag_1 == $past(mmr_i.wdata[10:0])) else $error("flag one write lost");
    a_enable_read: assert property (clk_en && mmr_i.rd && mmr_i.addr == 7'h45
        |=> mmr_rdata == {5'h00, $past(interrupt_enable_1)}) else $error("enable one read wrong");
    a_unmapped_zero: assert property (clk_en && mmr_i.rd && mmr_i.addr[6:5] == 2'b11 |=> mmr_rdata == 16'h0000)
        else $error("unmapped word read not zero");
    a_swap_refused: assert property (sw && !ok_pair |=> bad_instr) else $error("bad swap not flagged");
    a_swap_accepted: assert property (sw && ok_pair |=> !bad_instr) else $error("good swap flagged");
    a_legacy_shift: assert property (clk_en && legacy_compat_mode
        |=> tmp_o[47:32] == 16'($signed($past(accumulator_shift_mode_field)))) else $error("temp two not tied");
    a_dag_step: assert property (dag0 |=> ptr_o[15:0] == $past(ptr_o[15:0] + dag_i.step)
        && $stable(ptr_o[22:16])) else $error("pointer step wrong");
    a_trn_select: assert property (x40 |=> $past(cmd_i.trn_sel) ? $stable(trn_o[15:0]) : $stable(trn_o[31:16]))
        else $error("unselected transition changed");
endmodule
bind dcrf_core dcrf_core_chk i_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .mmr_i(mmr_i),
    .cmd_i(cmd_i), .dag_i(dag_i), .legacy_compat_mode(legacy_compat_mode), .mmr_rdata(mmr_rdata),
    .accumulator_shift_mode_field(accumulator_shift_mode_field), .tmp_o(tmp_o), .ptr_o(ptr_o), .trn_o(trn_o),
    .interrupt_enable_1(interrupt_enable_1), .interrupt_flag_1(interrupt_flag_1), .bad_instr(bad_instr));
`default_nettype wire

// ### tb/tb_dcrf_core.sv
// self-checking testbench for the cpu register file
`timescale 1ns/10ps
`default_nettype none
module tb_dcrf_core;
    import dcrf_pkg::*;
    logic clk_sys = 0, sys_rst = 1, clk_en = 1, legacy = 0, rd_q = 0, mx, bw;
    logic [4:0] shf = 5'h13;
    dcrf_mmr_s mmr = '0;
    dcrf_cmd_s cmd = '0;
    dcrf_alu_e fn = AF_ADD;
    dcrf_dag_s dag = '0;
    logic [15:0] mmr_rdata, status_two, w, m, tr[2];
    logic [159:0] acc_o;
    logic [63:0] tmp_o;
    logic [183:0] ptr_o;
    logic [31:0] trn_o;
    logic [10:0] ien, ifl;
    logic bad_instr;
    logic [22:0] p, pv[8];
    logic [39:0] exp_q[$], a, b, av[4];
    logic [6:0] ab[4] = '{A_ACC0, A_ACC1, A_ACC2, A_ACC3};
    dcrf_op_e xo[4] = '{OP_MAX_DUAL, OP_MIN_DUAL, OP_MAX_40, OP_MIN_40};
    int err_count = 0, checked = 0;
    always #10 clk_sys = ~clk_sys;
    dcrf_core i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .mmr_i(mmr), .cmd_i(cmd), .dag_i(dag),
        .legacy_compat_mode(legacy), .accumulator_shift_mode_field(shf), .mmr_rdata(mmr_rdata), .acc_o(acc_o),
        .tmp_o(tmp_o), .ptr_o(ptr_o), .trn_o(trn_o), .status_two(status_two), .interrupt_enable_1(ien),
        .interrupt_flag_1(ifl), .bad_instr(bad_instr));
    task automatic chk(input logic [39:0] g, input logic [39:0] e);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("BAD %0t mismatch got %h exp %h", $time, g, e);
        end
    endtask
    task automatic conclude;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [6:0] ad, input logic [15:0] d);
        @(posedge clk_sys);
        mmr <= '{1'b0, 1'b1, ad, d};
        @(posedge clk_sys);
        mmr <= '0;
    endtask
    task automatic rd(input logic [6:0] ad, input logic [39:0] e);
        @(posedge clk_sys);
        mmr <= '{1'b1, 1'b0, ad, 16'h0000};
        exp_q.push_back(e);
        @(posedge clk_sys);
        mmr <= '0;
    endtask
    task automatic op(input dcrf_op_e o, input logic [2:0] x, input logic [2:0] y, input logic s,
                      input logic [39:0] d, input logic bad);
        @(posedge clk_sys);
        cmd <= '{o, x, y, s, fn, d};
        @(posedge clk_sys);
        cmd <= '0;
        #1 chk(bad_instr, bad);
    endtask
    function automatic logic dec(input logic signed [39:0] x, input logic signed [39:0] y, input logic up);
        return up ? y > x : y < x;
    endfunction
    // read data lands one edge after the request, so compare on the falling edge after
    always @(posedge clk_sys) rd_q <= mmr.rd;
    always @(negedge clk_sys) if (rd_q) chk(mmr_rdata, exp_q.pop_front());
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        conclude();
    end
    initial begin
        void'($urandom(32'h6aa0_2f44));
        repeat (16) @(posedge clk_sys);
        sys_rst <= 0;
        // the walk stops short of the reserved words, which software must leave alone
        for (int k = 'h45; k <= 'h4f; k++) begin
            w = 16'($urandom);
            m = k inside {'h45, 'h46, 'h48} ? 16'h07ff : k inside {'h4e, 'h4f} ? 16'h007f : 16'hffff;
            rd(k[6:0], 0);
            wr(k[6:0], w);
            rd(k[6:0], w & m);
            if (k == 'h45) chk(ien, w[10:0]);
            if (k == 'h46) chk(ifl, w[10:0]);
            if (k == 'h4b) chk(status_two, w);
        end
        // words above the reserved span are unmapped: writes vanish, reads give zero
        for (int k = 'h60; k < 'h64; k++) begin
            wr(k[6:0], 16'($urandom));
            rd(k[6:0], 0);
        end
        $display("test map done");
        legacy <= 1;
        foreach (ab[k]) begin
            av[k] = 40'({$urandom, $urandom});
            op(OP_ACC_WR, k[2:0], 0, 0, av[k], 0);
            rd(ab[k], av[k][15:0]);
            rd(ab[k] + 7'h01, av[k][31:16]);
            rd(ab[k] + 7'h02, av[k][39:32]);
        end
        wr(A_TMP + 7'h02, 16'h5555);
        rd(A_TMP + 7'h02, 16'hfff3);
        op(OP_ACC_SWAP, 0, 2, 0, 0, 0);
        op(OP_ACC_SWAP, 3, 1, 0, 0, 0);
        op(OP_ACC_SWAP, 0, 1, 0, 0, 1);
        op(OP_ACC_SWAP, 2, 2, 0, 0, 1);
        foreach (ab[k]) rd(ab[k], av[k ^ 2][15:0]);
        $display("test accumulators done");
        tr = '{16'h0000, 16'h0000};
        foreach (xo[i]) begin
            a = 40'({$urandom, $urandom});
            b = 40'({$urandom, $urandom});
            mx = !i[0];
            op(OP_ACC_WR, 0, 0, 0, a, 0);
            op(OP_ACC_WR, 1, 0, 0, b, 0);
            op(xo[i], 0, 1, i[0], 0, 0);
            if (i < 2) begin
                tr[0] = {tr[0][14:0], dec($signed(a[31:16]), $signed(b[31:16]), mx)};
                tr[1] = {tr[1][14:0], dec($signed(a[15:0]), $signed(b[15:0]), mx)};
            end else begin
                bw = dec(a, b, mx);
                tr[i[0]] = {tr[i[0]][14:0], bw};
                chk(acc_o[39:0], bw ? b : a);
            end
            rd(A_TRANS0, tr[0]);
            rd(A_TRANS1, tr[1]);
        end
        $display("test extremum done");
        legacy <= 0;
        for (int k = 0; k < 8; k++) begin
            p = 23'($urandom);
            w = 16'($urandom);
            op(OP_XP_WR, 0, k[2:0], 0, 40'(p), 0);
            chk(ptr_o[k * 23 +: 23], p);
            wr(A_PTR + k[6:0], w);
            pv[k] = {p[22:16], w};
            if (k < 4) op(OP_T_WR, k[2:0], 0, 0, 40'(~w), 0);
            if (k < 4) rd(A_TMP + k[6:0], 16'(~w));
        end
        op(OP_SWAP_PT, 1, 5, 0, 0, 0);
        rd(A_TMP + 7'h01, pv[5][15:0]);
        rd(A_PTR + 7'h05, 16'(~pv[1][15:0]));
        dag <= '{1'b1, 3'd0, 16'h0123};
        op(OP_AU_ALU, 0, 1, 0, 40'h00_0000_4321, 0);
        dag <= '0;
        // with the enable low a write must leave the pointer as it was
        clk_en <= 0;
        wr(A_PTR, 16'h0000);
        clk_en <= 1;
        rd(A_PTR, 16'(pv[0][15:0] + 16'h0246));
        rd(A_PTR + 7'h01, 16'(pv[1][15:0] + 16'h4321));
        p[15:0] = pv[2][15:0];
        for (int j = 1; j < 7; j++) begin
            fn = dcrf_alu_e'(j);
            w = 16'($urandom);
            op(OP_AU_ALU, 0, 3'd2, 0, 40'(w), 0);
            case (fn)
                AF_SUB:  p[15:0] = p[15:0] - w;
                AF_AND:  p[15:0] = p[15:0] & w;
                AF_OR:   p[15:0] = p[15:0] | w;
                AF_XOR:  p[15:0] = p[15:0] ^ w;
                AF_SHL:  p[15:0] = p[15:0] << w[3:0];
                default: p[15:0] = 16'($signed(p[15:0]) >>> w[3:0]);
            endcase
            rd(A_PTR + 7'h02, p[15:0]);
        end
        fn = AF_ADD;
        #1 chk(ptr_o[22:16], pv[0][22:16]);
        $display("test pointers done");
        repeat (3) @(posedge clk_sys);
        conclude();
    end
endmodule
`default_nettype wire
